// *** rtl/eqrl_defs.vh ***
// Purpose: Constants for the egress queue rate-limit register bank
// Assumes: 8-bit management register port, byte addresses
// Notes:   Offsets, reset values and shaper timing counts
`ifndef EQRL_DEFS_VH
`define EQRL_DEFS_VH

// ==========================================================
// Register offsets
`define EQRL_P1_Q1_CAP     8'hBD
`define EQRL_P1_Q2_CAP     8'hBE
`define EQRL_FACTORY_TEST1 8'hBF
`define EQRL_P2_Q1_CAP     8'hCC
`define EQRL_P2_Q2_CAP     8'hCD
`define EQRL_P2_Q3_CAP     8'hCE
`define EQRL_RESV_CTRL     8'hCF
`define EQRL_P3_Q1_CAP     8'hDC
`define EQRL_P3_Q2_CAP     8'hDD
`define EQRL_P3_Q3_CAP     8'hDE
`define EQRL_P4_Q1_CAP     8'hEC
`define EQRL_P4_Q2_CAP     8'hED
`define EQRL_P4_Q3_CAP     8'hEE

// ==========================================================
// Fields and reset values
`define EQRL_CAP_MSB       6
`define EQRL_CAP_RESET     7'h00
`define EQRL_FACTORY_VAL   8'h80
`define EQRL_RESV_VAL      8'h15
`define EQRL_NO_LIMIT      7'h64
`define EQRL_MAX_100       7'h63
`define EQRL_MAX_10        7'h09

// ==========================================================
// Shaper timing: one credit token per microsecond per Mbps
`define EQRL_TICK_NS       1000
`define EQRL_CLK_NS        40
`define EQRL_TICK_CYC      (`EQRL_TICK_NS / `EQRL_CLK_NS)
`define EQRL_TICK_W        5
// Last divider count, one below the cycles per tick
`define EQRL_TICK_LAST     5'h18
`define EQRL_CRED_W        12
// Credit bucket depth in bits, 200 bytes
`define EQRL_CRED_MAX      12'h640

`endif

// *** rtl/eqrl_shaper.v ***
// Purpose: Token shaper for one egress queue
// Assumes: tick is a one-cycle pulse every microsecond
// Notes:   Each tick adds rate bits of credit; byte consumes 8
`timescale 1ns/1ps
`include "eqrl_defs.vh"

module eqrl_shaper (
    // Clock and reset
    input  wire       mclk,
    input  wire       resetn,
    // Control
    input  wire       tick,
    input  wire [6:0] rate,
    input  wire       unlimited,
    input  wire       byte_sent,
    // Status
    output reg        may_send
);

    reg  [`EQRL_CRED_W-1:0] cred_q;
    reg  [`EQRL_CRED_W-1:0] cred_d;

    always @* begin
        cred_d = cred_q;
        if (tick) begin
            if (cred_q + {5'h00, rate} > `EQRL_CRED_MAX)
                cred_d = `EQRL_CRED_MAX;
            else
                cred_d = cred_q + {5'h00, rate};
        end
        if (byte_sent && !unlimited) begin
            if (cred_d >= 12'h008)
                cred_d = cred_d - 12'h008;
            else
                cred_d = 12'h000;
        end
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cred_q   <= 12'h000;
            may_send <= 1'b0;
        end else begin
            cred_q   <= cred_d;
            may_send <= unlimited || (cred_d >= 12'h008);
        end
    end

endmodule

// *** rtl/eqrl_regs.v ***
// Purpose: Per-port egress queue rate-limit registers and shaping
// Assumes: Byte-wide management register port, switch core clock
// Notes:   Ports 1..4, queues 1..3 (port 1 queues 1..2 only); one-cycle read latency
`timescale 1ns/1ps
`include "eqrl_defs.vh"

// Contract
// - Queue 1 limit is a read/write 7-bit field in bits 6..0 reset to zero.
// - Queue 2 limit is a read/write 7-bit field in bits 6..0 reset to zero.
// - Queue 3 limit is a read/write 7-bit field in bits 6..0 reset to zero.
// - Each queue is shaped so its rate never exceeds its decoded limit.
// - In four-queue mode queue 1 ranks above queue 0 and below queue 2.
// - In two-queue mode queue 1 is the high-priority queue.
// - In four-queue mode queue 2 ranks above queue 1 and below queue 3.
// - In four-queue mode queue 3 is the highest priority of the port.
// - At 100 Mbps values 1..99 cap in Mbps; 0 or 100 mean no limit.
// - At 10 Mbps values 1..9 cap in Mbps; 0 or 100 disable the cap.
// - With several queues only the top queue gets its exact rate, others by ratio.
module eqrl_regs (
    // Clock and reset
    input  wire        mclk,
    input  wire        resetn,
    // Register port
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    // Port configuration, one bit per port 1..4
    input  wire [3:0]  four_queue,
    input  wire [3:0]  two_queue,
    input  wire [3:0]  speed_100,
    // Ratio grants from port ratio control, per port and queue
    input  wire [11:0] ratio_ok,
    // Egress activity, byte_sent per port and queue, frame_idle per port
    input  wire [11:0] byte_sent,
    input  wire [3:0]  frame_idle,
    // Scheduler outputs
    output reg  [11:0] q_may_send,
    output reg  [7:0]  q_top_sel
);

    // ======================================================
    // Register storage, index = (port-1)*3 + (queue-1)
    reg  [6:0]  cap_q    [0:11];
    reg  [6:0]  act_q    [0:11];
    reg  [11:0] hit;
    reg  [7:0]  rdata_d;
    reg  [11:0] unlim_d;
    reg  [`EQRL_TICK_W-1:0] tick_cnt_q;
    reg         tick_q;
    wire [11:0] shp_ok;
    integer     i;
    integer     j;
    integer     k;

    always @* begin
        hit = 12'h000;
        case (reg_addr)
            `EQRL_P1_Q1_CAP: hit[0]  = 1'b1;
            `EQRL_P1_Q2_CAP: hit[1]  = 1'b1;
            `EQRL_P2_Q1_CAP: hit[3]  = 1'b1;
            `EQRL_P2_Q2_CAP: hit[4]  = 1'b1;
            `EQRL_P2_Q3_CAP: hit[5]  = 1'b1;
            `EQRL_P3_Q1_CAP: hit[6]  = 1'b1;
            `EQRL_P3_Q2_CAP: hit[7]  = 1'b1;
            `EQRL_P3_Q3_CAP: hit[8]  = 1'b1;
            `EQRL_P4_Q1_CAP: hit[9]  = 1'b1;
            `EQRL_P4_Q2_CAP: hit[10] = 1'b1;
            `EQRL_P4_Q3_CAP: hit[11] = 1'b1;
            default:         hit     = 12'h000;
        endcase
    end

    // ======================================================
    // Write path; fixed registers and unmapped offsets ignore writes
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (i = 0; i < 12; i = i + 1)
                cap_q[i] <= `EQRL_CAP_RESET;
        end else if (reg_wr) begin
            for (i = 0; i < 12; i = i + 1)
                if (hit[i])
                    cap_q[i] <= reg_wdata[`EQRL_CAP_MSB:0];
        end
    end

    // ======================================================
    // Read path; bit 7 of limit registers reads zero, test registers fixed
    always @* begin
        rdata_d = 8'h00;
        case (reg_addr)
            `EQRL_FACTORY_TEST1: rdata_d = `EQRL_FACTORY_VAL;
            `EQRL_RESV_CTRL:     rdata_d = `EQRL_RESV_VAL;
            `EQRL_P1_Q1_CAP:     rdata_d = {1'b0, cap_q[0]};
            `EQRL_P1_Q2_CAP:     rdata_d = {1'b0, cap_q[1]};
            `EQRL_P2_Q1_CAP:     rdata_d = {1'b0, cap_q[3]};
            `EQRL_P2_Q2_CAP:     rdata_d = {1'b0, cap_q[4]};
            `EQRL_P2_Q3_CAP:     rdata_d = {1'b0, cap_q[5]};
            `EQRL_P3_Q1_CAP:     rdata_d = {1'b0, cap_q[6]};
            `EQRL_P3_Q2_CAP:     rdata_d = {1'b0, cap_q[7]};
            `EQRL_P3_Q3_CAP:     rdata_d = {1'b0, cap_q[8]};
            `EQRL_P4_Q1_CAP:     rdata_d = {1'b0, cap_q[9]};
            `EQRL_P4_Q2_CAP:     rdata_d = {1'b0, cap_q[10]};
            `EQRL_P4_Q3_CAP:     rdata_d = {1'b0, cap_q[11]};
            default:             rdata_d = 8'h00;
        endcase
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end
    end

    // ======================================================
    // Active limits latch only between frames
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (j = 0; j < 12; j = j + 1)
                act_q[j] <= `EQRL_CAP_RESET;
        end else begin
            // Held while the port is mid-frame
            for (j = 0; j < 12; j = j + 1)
                if (frame_idle[j/3])
                    act_q[j] <= cap_q[j];
        end
    end

    // ======================================================
    // One-microsecond tick divider
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_q <= 5'h00;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == `EQRL_TICK_LAST) begin
            tick_cnt_q <= 5'h00;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 5'h01;
            tick_q     <= 1'b0;
        end
    end

    // ======================================================
    // Rate decode; 0, 100 and out-of-range values leave a queue unshaped
    always @* begin
        unlim_d = 12'h000;
        for (k = 0; k < 12; k = k + 1) begin
            if (act_q[k] == `EQRL_CAP_RESET)
                unlim_d[k] = 1'b1;
            else if (act_q[k] == `EQRL_NO_LIMIT)
                unlim_d[k] = 1'b1;
            else if (speed_100[k/3] && (act_q[k] > `EQRL_MAX_100))
                unlim_d[k] = 1'b1;
            else if (!speed_100[k/3] && (act_q[k] > `EQRL_MAX_10))
                unlim_d[k] = 1'b1;
        end
    end

    // ======================================================
    // Per-queue shapers
    genvar g;
    generate
        for (g = 0; g < 12; g = g + 1) begin : g_shp
            eqrl_shaper u_shp (
                .mclk      (mclk),
                .resetn    (resetn),
                .tick      (tick_q),
                .rate      (act_q[g]),
                .unlimited (unlim_d[g]),
                .byte_sent (byte_sent[g]),
                .may_send  (shp_ok[g])
            );
        end
    endgenerate

    // ======================================================
    // Queue ranking: q_top_sel two bits per port, top queue index
    // Top queue codes
    localparam [1:0] TOP_NONE = 2'h0;
    localparam [1:0] TOP_Q1   = 2'h1;
    localparam [1:0] TOP_Q3   = 2'h3;
    reg [11:0] send_d;
    reg [7:0]  top_d;
    integer    p;
    always @* begin
        send_d = 12'h000;
        top_d  = 8'h00;
        for (p = 0; p < 4; p = p + 1) begin
            // Four-queue mode wins over two-queue mode
            if (four_queue[p]) begin
                top_d[p*2 +: 2] = TOP_Q3;
                send_d[p*3+2]   = shp_ok[p*3+2];
                // Lower queues also wait for their ratio grant
                send_d[p*3+1]   = shp_ok[p*3+1] & ratio_ok[p*3+1];
                send_d[p*3]     = shp_ok[p*3] & ratio_ok[p*3];
            end else if (two_queue[p]) begin
                // Queues 2 and 3 stay idle
                top_d[p*2 +: 2] = TOP_Q1;
                send_d[p*3]     = shp_ok[p*3];
            end else begin
                top_d[p*2 +: 2] = TOP_NONE;
            end
        end
    end

    // ======================================================
    // Registered scheduler outputs
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q_may_send <= 12'h000;
            q_top_sel  <= 8'h00;
        end else begin
            q_may_send <= send_d;
            q_top_sel  <= top_d;
        end
    end

endmodule

// *** verif/eqrl_regs_props.sv ***
// Purpose: Port-level properties of the rate-limit register bank
// Assumes: One-cycle read latency, registered scheduler outputs
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
module eqrl_regs_props (
    // Clock and reset
    input wire        mclk,
    input wire        resetn,
    // Register port
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire [7:0]  reg_rdata,
    // Configuration and traffic
    input wire [3:0]  four_queue,
    input wire [3:0]  two_queue,
    input wire [3:0]  speed_100,
    input wire [11:0] ratio_ok,
    input wire [11:0] byte_sent,
    input wire [3:0]  frame_idle,
    input wire [11:0] q_may_send,
    input wire [7:0]  q_top_sel
);
    default clocking dclk @(posedge mclk); endclocking
    default disable iff (!resetn);
    // ==========================================================
    // Register port
    q1_readback_a: assert property (reg_wr && reg_addr == 8'hCC ##1 reg_rd && !reg_wr &&
        reg_addr == 8'hCC |=> reg_rdata == {1'b0, $past(reg_wdata[6:0], 2)})
        else $error("queue 1 limit readback wrong");
    q2_readback_a: assert property (reg_wr && reg_addr == 8'hDD ##1 reg_rd && !reg_wr &&
        reg_addr == 8'hDD |=> reg_rdata == {1'b0, $past(reg_wdata[6:0], 2)})
        else $error("queue 2 limit readback wrong");
    // ==========================================================
    // Queue ranking
    q3_top_a: assert property (four_queue[0] [*3] |-> q_top_sel[1:0] == 2'h3)
        else $error("queue 3 not top in four-queue mode");
    q1_high_a: assert property ((two_queue[1] && !four_queue[1]) [*3] |->
        q_top_sel[3:2] == 2'h1) else $error("queue 1 not top in two-queue mode");
    two_off_a: assert property ((two_queue[2] && !four_queue[2]) [*3] |->
        q_may_send[8:7] == 2'h0) else $error("upper queues send in two-queue mode");
    ratio_gate_a: assert property ((four_queue[3] && !ratio_ok[9]) [*3] |->
        !q_may_send[9]) else $error("queue 1 sends without ratio grant");
    q2_ratio_a: assert property ((four_queue[3] && !ratio_ok[10]) [*3] |->
        !q_may_send[10]) else $error("queue 2 sends without ratio grant");
    single_top_a: assert property ((!four_queue[0] && !two_queue[0]) [*3] |->
        q_top_sel[1:0] == 2'h0) else $error("top select wrong in single-queue mode");
endmodule

// *** verif/eqrl_regs_bench.sv ***
// Purpose: Self-checking bench for the rate-limit register bank
// Assumes: Port 1 in two-queue mode for rate measurement
// Notes:   Sender paces one byte per three cycles at most
`timescale 1ns/1ps
module eqrl_regs_bench;
    localparam [111:0] OFFS = 112'hBDBEBFCCCDCECFDCDDDEECEDEE40;
    reg         mclk, resetn, reg_wr, reg_rd, m;
    reg  [7:0]  reg_addr, reg_wdata, a, shadow [0:255];
    reg  [3:0]  four_queue, two_queue, speed_100, frame_idle;
    reg  [11:0] ratio_ok, byte_sent;
    reg  [31:0] seed;
    wire [7:0]  reg_rdata, q_top_sel;
    wire [11:0] q_may_send;
    integer     bad_count, checked, i, cnt, gap;
    eqrl_regs uut (.mclk(mclk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .four_queue(four_queue), .two_queue(two_queue), .speed_100(speed_100),
        .ratio_ok(ratio_ok), .byte_sent(byte_sent), .frame_idle(frame_idle),
        .q_may_send(q_may_send), .q_top_sel(q_top_sel));
    function [31:0] xs(input [31:0] s);
        begin
            s = s ^ (s << 13);
            s = s ^ (s >> 17);
            xs = s ^ (s << 5);
        end
    endfunction
    function [7:0] exp_rd(input [7:0] x);
        case (x)
            8'hBF: exp_rd = 8'h80;
            8'hCF: exp_rd = 8'h15;
            8'h40: exp_rd = 8'h00;
            default: exp_rd = {1'b0, shadow[x][6:0]};
        endcase
    endfunction
    function [7:0] exp_top(input [3:0] f, input [3:0] t);
        integer k;
        begin
            exp_top = 8'h00;
            for (k = 0; k < 4; k = k + 1)
                exp_top[2*k +: 2] = f[k] ? 2'h3 : (t[k] ? 2'h1 : 2'h0);
        end
    endfunction
    function [11:0] exp_gate(input [3:0] f, input [3:0] t, input [11:0] r);
        integer k;
        begin
            exp_gate = 12'h000;
            for (k = 0; k < 4; k = k + 1)
                if (f[k])
                    exp_gate[3*k +: 3] = {1'b1, r[3*k+1], r[3*k]};
                else if (t[k])
                    exp_gate[3*k] = 1'b1;
        end
    endfunction
    task check(input [127:0] what, input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("wrong value %0s expected %0h seen %0h", what, exp, seen);
            end
        end
    endtask
    task acc(input w, input rd, input [7:0] x, input [7:0] d);
        begin
            @(posedge mclk);
            reg_wr <= w;
            reg_rd <= rd;
            reg_addr <= x;
            reg_wdata <= d;
        end
    endtask
    task rd_chk(input [7:0] x);
        begin
            acc(0, 1, x, 8'h00);
            acc(0, 0, x, 8'h00);
            #1 check("reg_rdata", reg_rdata, exp_rd(x));
        end
    endtask
    task rate_run(input sp, input [6:0] v, input integer e);
        begin
            speed_100[0] <= sp;
            acc(1, 0, 8'hBD, {1'b0, v});
            cnt = 0;
            gap = 0;
            for (i = 0; i < 7000; i = i + 1) begin
                @(negedge mclk) m = q_may_send[0];
                @(posedge mclk);
                reg_wr <= 0;
                byte_sent[0] <= m && gap == 0;
                if (m && gap == 0) begin
                    gap = 2;
                    if (i >= 2000) cnt = cnt + 1;
                end else if (gap > 0) gap = gap - 1;
            end
            check("rate", cnt >= e - e / 16 - 3 && cnt <= e + e / 16 + 3, 1);
            $display("rate test speed %0d value %0d bytes %0d", sp, v, cnt);
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", checked, bad_count);
            if (bad_count == 0 && checked > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        mclk = 0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, byte_sent, four_queue} = 0;
        {two_queue, speed_100, frame_idle, ratio_ok} = 24'h1FFFFF;
        resetn = 0;
        seed = 32'h06B12FFA;
        bad_count = 0;
        checked = 0;
        for (i = 0; i < 256; i = i + 1) shadow[i] = 8'h00;
        repeat (2) @(posedge mclk);
        resetn <= 1;
        for (i = 0; i < 14; i = i + 1) rd_chk(OFFS[8 * i +: 8]);
        $display("reset values test done");
        for (i = 0; i < 400; i = i + 1) begin
            seed = xs(seed);
            {ratio_ok, two_queue, four_queue} <= seed[19:0];
            a = OFFS[8 * (seed[31:28] % 14) +: 8];
            acc(1, 0, a, seed[27:20]);
            if (a != 8'hBF && a != 8'hCF) shadow[a] = seed[27:20];
            rd_chk(a);
            check("q_top_sel", q_top_sel, exp_top(four_queue, two_queue));
            check("q_may_send", q_may_send & ~exp_gate(four_queue, two_queue, ratio_ok), 0);
        end
        $display("random access test done");
        {four_queue, two_queue, ratio_ok} <= 20'h01FFF;
        rate_run(1, 7'h01, 25);
        rate_run(1, 7'h28, 1000);
        frame_idle[0] <= 1'b0;
        rate_run(1, 7'h01, 1000);
        frame_idle[0] <= 1'b1;
        rate_run(1, 7'h64, 1666);
        rate_run(0, 7'h09, 225);
        rate_run(0, 7'h00, 1666);
        summarize;
    end
endmodule
bind eqrl_regs eqrl_regs_props chk (.mclk(mclk), .resetn(resetn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .four_queue(four_queue), .two_queue(two_queue), .speed_100(speed_100),
    .ratio_ok(ratio_ok), .byte_sent(byte_sent), .frame_idle(frame_idle),
    .q_may_send(q_may_send), .q_top_sel(q_top_sel));
